// >>> hdl/icva_core.sv
`timescale 1ns/1ps
`default_nettype none
module icva_core #(
    parameter int CV_DEPTH = 1024
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Variable write
    input  wire logic                    wr_valid,
    input  wire icva_pkg::icva_cv_wr_s   wr_req,
    output logic                         wr_ready,
    // Variable read
    input  wire logic                    rd_valid,
    input  wire icva_pkg::icva_cv_num_t  rd_num,
    output logic                         rd_ready,
    output logic                         rd_data_valid,
    output icva_pkg::icva_byte_t         rd_data,
    // Status
    output icva_pkg::icva_addr_sel_s     addr_sel,
    output logic                         xfer_done,
    output logic                         xfer_discard
);

    if (CV_DEPTH < 1000 || CV_DEPTH > 1024) begin : g_depth_chk
        $error("icva_core: CV_DEPTH must lie in 1000..1024");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    icva_pkg::icva_byte_t   short_address, next_short_address;
    icva_pkg::icva_byte_t   long_address_high, next_long_address_high;
    icva_pkg::icva_byte_t   long_address_low, next_long_address_low;
    icva_pkg::icva_byte_t   basic_config, next_basic_config;
    icva_pkg::icva_byte_t   indirect_target_hundreds, next_indirect_target_hundreds;
    icva_pkg::icva_byte_t   indirect_target_tens_units, next_indirect_target_tens_units;
    icva_pkg::icva_byte_t   indirect_value_hundreds, next_indirect_value_hundreds;
    logic                   four_mode, next_four_mode;
    logic                   next_xfer_done, next_xfer_discard;
    icva_pkg::icva_addr_sel_s next_addr_sel;

    // Write decode
    logic                   wr_fire, trigger;
    logic [10:0]            tgt_num, val_sum;
    logic                   tgt_ok, val_ok;
    logic                   eff_we;
    icva_pkg::icva_cv_num_t eff_num;
    icva_pkg::icva_byte_t   eff_data;
    logic                   mem_we;
    icva_pkg::icva_cv_num_t mem_addr;
    icva_pkg::icva_byte_t   mem_rdata;

    // Read pipeline
    logic                   rd_fire;
    logic                   rd_p1, next_rd_p1;
    logic                   rd_p1_helper, next_rd_p1_helper;
    icva_pkg::icva_byte_t   rd_p1_value, next_rd_p1_value;
    logic                   next_rd_data_valid;
    icva_pkg::icva_byte_t   next_rd_data;

    // ****************************************************************
    // Indirect write decode
    // ****************************************************************
    // A write always completes in its own cycle, so the port never stalls
    assign wr_ready = 1'b1;
    assign wr_fire  = wr_valid;
    // Helper 99 is the last write of a sequence and fires the copy
    assign trigger  = wr_fire && (wr_req.num == icva_pkg::CV_VAL_TRIGGER);

    // Target number from both address helpers
    assign tgt_num = icva_pkg::icva_dec3(indirect_target_hundreds, indirect_target_tens_units);
    // Helpers themselves and variable 0 are not valid targets
    assign tgt_ok  = icva_pkg::icva_digits_ok(indirect_target_hundreds, indirect_target_tens_units)
                     && (tgt_num != 11'h000) && (tgt_num < 11'(CV_DEPTH))
                     && !((tgt_num >= 11'(icva_pkg::CV_TGT_HUNDREDS))
                          && (tgt_num <= 11'(icva_pkg::CV_VAL_TRIGGER)));
    // Four-variable value combines hundreds with tens and units
    assign val_sum = icva_pkg::icva_dec3(indirect_value_hundreds, wr_req.data);
    assign val_ok  = !four_mode
                     || (icva_pkg::icva_digits_ok(indirect_value_hundreds, wr_req.data)
                         && (val_sum <= icva_pkg::BYTE_MAX));

    // Effective store: plain write or redirected copy
    always_comb begin
        eff_we   = 1'b0;
        eff_num  = wr_req.num;
        eff_data = wr_req.data;
        if (trigger) begin
            eff_we   = tgt_ok && val_ok;
            eff_num  = icva_pkg::icva_cv_num_t'(tgt_num);
            eff_data = four_mode ? icva_pkg::icva_byte_t'(val_sum) : wr_req.data;
        end else if (wr_fire) begin
            eff_we = (11'(wr_req.num) < 11'(CV_DEPTH))
                     && !((wr_req.num >= icva_pkg::CV_TGT_HUNDREDS)
                          && (wr_req.num <= icva_pkg::CV_VAL_TRIGGER));
        end
    end

    assign mem_we   = eff_we;
    assign mem_addr = eff_we ? eff_num : rd_num;

    // ****************************************************************
    // Helper and shadow registers
    // ****************************************************************
    // Shadows mirror every store, so indirect copies reach them too
    always_comb begin
        next_short_address              = short_address;
        next_long_address_high          = long_address_high;
        next_long_address_low           = long_address_low;
        next_basic_config               = basic_config;
        next_indirect_target_hundreds   = indirect_target_hundreds;
        next_indirect_target_tens_units = indirect_target_tens_units;
        next_indirect_value_hundreds    = indirect_value_hundreds;
        next_four_mode                  = four_mode;
        next_xfer_done                  = trigger && eff_we;
        next_xfer_discard               = trigger && !eff_we;
        if (eff_we) begin
            case (eff_num)
                icva_pkg::CV_SHORT_ADDRESS:  next_short_address     = eff_data;
                icva_pkg::CV_LONG_ADDR_HIGH: next_long_address_high = eff_data;
                icva_pkg::CV_LONG_ADDR_LOW:  next_long_address_low  = eff_data;
                icva_pkg::CV_BASIC_CONFIG:   next_basic_config      = eff_data;
                default: ;
            endcase
        end
        if (trigger) begin
            // Cleared whether the copy was stored or dropped
            next_indirect_target_hundreds   = icva_pkg::RST_HELPER;
            next_indirect_target_tens_units = icva_pkg::RST_HELPER;
            next_indirect_value_hundreds    = icva_pkg::RST_HELPER;
            next_four_mode                  = 1'b0;
        end else if (wr_fire) begin
            case (wr_req.num)
                icva_pkg::CV_TGT_HUNDREDS:   next_indirect_target_hundreds   = wr_req.data;
                icva_pkg::CV_TGT_TENS_UNITS: next_indirect_target_tens_units = wr_req.data;
                icva_pkg::CV_VAL_HUNDREDS: begin
                    next_indirect_value_hundreds = wr_req.data;
                    next_four_mode               = 1'b1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            short_address              <= icva_pkg::RST_SHORT_ADDRESS;
            long_address_high          <= icva_pkg::RST_LONG_ADDR_HIGH;
            long_address_low           <= icva_pkg::RST_LONG_ADDR_LOW;
            basic_config               <= icva_pkg::RST_BASIC_CONFIG;
            indirect_target_hundreds   <= icva_pkg::RST_HELPER;
            indirect_target_tens_units <= icva_pkg::RST_HELPER;
            indirect_value_hundreds    <= icva_pkg::RST_HELPER;
            four_mode                  <= 1'b0;
            xfer_done                  <= 1'b0;
            xfer_discard               <= 1'b0;
        end else begin
            short_address              <= next_short_address;
            long_address_high          <= next_long_address_high;
            long_address_low           <= next_long_address_low;
            basic_config               <= next_basic_config;
            indirect_target_hundreds   <= next_indirect_target_hundreds;
            indirect_target_tens_units <= next_indirect_target_tens_units;
            indirect_value_hundreds    <= next_indirect_value_hundreds;
            four_mode                  <= next_four_mode;
            xfer_done                  <= next_xfer_done;
            xfer_discard               <= next_xfer_discard;
        end
    end

    // ****************************************************************
    // Address selection
    // ****************************************************************
    // One address only; an out-of-range value leaves the decoder deaf
    always_comb begin
        next_addr_sel         = '0;
        next_addr_sel.is_long = basic_config[icva_pkg::ADDR_SEL_BIT];
        if (next_addr_sel.is_long) begin
            next_addr_sel.address = {6'(long_address_high & icva_pkg::LONG_HIGH_MASK), long_address_low};
            next_addr_sel.valid   = (next_addr_sel.address >= icva_pkg::LONG_MIN)
                                    && (next_addr_sel.address <= icva_pkg::LONG_MAX);
        end else begin
            next_addr_sel.address = 14'(short_address);
            next_addr_sel.valid   = (short_address >= icva_pkg::SHORT_MIN)
                                    && (short_address <= icva_pkg::SHORT_MAX);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_sel <= '0;
        end else begin
            addr_sel <= next_addr_sel;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Writes own the single memory port; reads wait while wr_valid is high
    assign rd_ready = !wr_valid;
    assign rd_fire  = rd_valid && rd_ready;

    always_comb begin
        next_rd_p1        = rd_fire;
        next_rd_p1_helper = (11'(rd_num) >= 11'(CV_DEPTH));
        next_rd_p1_value  = '0;
        case (rd_num)
            icva_pkg::CV_TGT_HUNDREDS:   begin next_rd_p1_helper = 1'b1; next_rd_p1_value = indirect_target_hundreds; end
            icva_pkg::CV_TGT_TENS_UNITS: begin next_rd_p1_helper = 1'b1; next_rd_p1_value = indirect_target_tens_units; end
            icva_pkg::CV_VAL_HUNDREDS:   begin next_rd_p1_helper = 1'b1; next_rd_p1_value = indirect_value_hundreds; end
            icva_pkg::CV_VAL_TRIGGER:    next_rd_p1_helper = 1'b1;
            default: ;
        endcase
        next_rd_data_valid = rd_p1;
        next_rd_data       = rd_p1 ? (rd_p1_helper ? rd_p1_value : mem_rdata) : rd_data;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_p1         <= 1'b0;
            rd_p1_helper  <= 1'b0;
            rd_p1_value   <= '0;
            rd_data_valid <= 1'b0;
            rd_data       <= '0;
        end else begin
            rd_p1         <= next_rd_p1;
            rd_p1_helper  <= next_rd_p1_helper;
            rd_p1_value   <= next_rd_p1_value;
            rd_data_valid <= next_rd_data_valid;
            rd_data       <= next_rd_data;
        end
    end

    icva_cv_mem #(
        .DEPTH  (CV_DEPTH),
        .ADDR_W (icva_pkg::CV_NUM_W),
        .DATA_W (icva_pkg::DATA_W)
    ) icva_cv_mem_inst (
        .clk   (clk),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata (eff_data),
        .rdata (mem_rdata)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_three_copy: assert property (trigger && !four_mode && tgt_ok
        |-> mem_we && eff_data == wr_req.data ##1 xfer_done) else $error("three-variable copy missing");
    chk_target_number: assert property (trigger && tgt_ok && val_ok
        |-> mem_addr == 10'(indirect_target_hundreds * 100 + indirect_target_tens_units))
        else $error("copy target number wrong");
    chk_helpers_clear: assert property (trigger |=> indirect_target_hundreds == 8'h00
        && indirect_target_tens_units == 8'h00 && indirect_value_hundreds == 8'h00 && !four_mode)
        else $error("helpers not cleared after copy");
    chk_four_value: assert property (trigger && four_mode && tgt_ok && val_ok
        |-> mem_we && eff_data == 8'(indirect_value_hundreds * 100 + wr_req.data))
        else $error("four-variable value wrong");
    chk_value_hundreds: assert property (wr_fire && wr_req.num == icva_pkg::CV_VAL_HUNDREDS
        |=> four_mode && indirect_value_hundreds == $past(wr_req.data)) else $error("value hundreds not held");
    chk_short_select: assert property (!basic_config[5] && short_address inside {[1:127]}
        |=> addr_sel.valid && !addr_sel.is_long && addr_sel.address == 14'($past(short_address)))
        else $error("short address not selected");
    chk_long_select: assert property (basic_config[5] |=> addr_sel.is_long
        && addr_sel.address == 14'(($past(long_address_high) % 8'h40) * 14'h0100 + $past(long_address_low))
        && addr_sel.valid == (addr_sel.address inside {[icva_pkg::LONG_MIN:icva_pkg::LONG_MAX]}))
        else $error("long address not selected");
    chk_select_bit: assert property ((wr_fire && wr_req.num == icva_pkg::CV_BASIC_CONFIG
        && wr_req.data[5]) ##1 !(wr_fire && wr_req.num == icva_pkg::CV_BASIC_CONFIG)
        |=> addr_sel.is_long) else $error("select bit 5 ignored");
    chk_bad_discard: assert property (trigger && !(tgt_ok && val_ok)
        |-> !mem_we ##1 xfer_discard && !xfer_done) else $error("bad transfer not dropped");
    chk_read_latency: assert property (rd_fire |-> ##2 rd_data_valid)
        else $error("read answer late");

    cov_three_xfer: cover property (trigger && !four_mode && tgt_ok);
    cov_four_xfer: cover property (trigger && four_mode && tgt_ok && val_ok);
    cov_discard: cover property (xfer_discard);
    cov_long_active: cover property (addr_sel.valid && addr_sel.is_long);

endmodule // icva_core
`default_nettype wire

// >>> hdl/icva_pkg.sv
// ****************************************************************
// Constants, types and helpers of the indirect variable writer
// ****************************************************************
package icva_pkg;

    // Widths
    localparam int CV_NUM_W = 10;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 14;

    typedef logic [CV_NUM_W-1:0] icva_cv_num_t;
    typedef logic [DATA_W-1:0]   icva_byte_t;
    typedef logic [ADDR_W-1:0]   icva_dcc_addr_t;

    // Variable numbers of the registers held in flip-flops and of the value trigger
    localparam icva_cv_num_t CV_SHORT_ADDRESS   = 10'h001;
    localparam icva_cv_num_t CV_LONG_ADDR_HIGH  = 10'h011;
    localparam icva_cv_num_t CV_LONG_ADDR_LOW   = 10'h012;
    localparam icva_cv_num_t CV_BASIC_CONFIG    = 10'h01d;
    localparam icva_cv_num_t CV_TGT_HUNDREDS    = 10'h060;
    localparam icva_cv_num_t CV_TGT_TENS_UNITS  = 10'h061;
    localparam icva_cv_num_t CV_VAL_HUNDREDS    = 10'h062;
    localparam icva_cv_num_t CV_VAL_TRIGGER     = 10'h063;

    // Field positions and limits
    localparam int             ADDR_SEL_BIT   = 5;
    localparam icva_byte_t     DIGIT_MAX      = 8'h09;
    localparam icva_byte_t     TWO_DIGIT_MAX  = 8'h63;
    localparam icva_byte_t     SHORT_MIN      = 8'h01;
    localparam icva_byte_t     SHORT_MAX      = 8'h7f;
    localparam icva_byte_t     LONG_HIGH_MASK = 8'h3f;
    localparam icva_dcc_addr_t LONG_MIN       = 14'h0080;
    localparam icva_dcc_addr_t LONG_MAX       = 14'h27ff;
    localparam logic [10:0]    BYTE_MAX       = 11'h0ff;

    // Values after reset
    localparam icva_byte_t RST_SHORT_ADDRESS  = 8'h03;
    localparam icva_byte_t RST_LONG_ADDR_HIGH = 8'hc0;
    localparam icva_byte_t RST_LONG_ADDR_LOW  = 8'h00;
    localparam icva_byte_t RST_BASIC_CONFIG   = 8'h00;
    localparam icva_byte_t RST_HELPER         = 8'h00;

    // Read pipeline depth in cycles
    localparam int RD_LATENCY = 2;

    // One variable write from the track decoder
    typedef struct packed {
        icva_cv_num_t num;
        icva_byte_t   data;
    } icva_cv_wr_s;

    // Active address presented to the packet filter
    typedef struct packed {
        icva_dcc_addr_t address;
        logic           is_long;
        logic           valid;
    } icva_addr_sel_s;

    // Hundreds digit times one hundred plus two-digit part
    function automatic logic [10:0] icva_dec3(input icva_byte_t hund, input icva_byte_t tens_units);
        logic [10:0] prod;
        prod = 11'(11'(hund) * 11'd100);
        return 11'(prod + 11'(tens_units));
    endfunction

    // True for a digit 0..9 and a two-digit part 0..99
    function automatic logic icva_digits_ok(input icva_byte_t hund, input icva_byte_t tens_units);
        return (hund <= DIGIT_MAX) && (tens_units <= TWO_DIGIT_MAX);
    endfunction

endpackage

// >>> hdl/icva_cv_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Single-port variable store with registered read data
// ****************************************************************
module icva_cv_mem #(
    parameter int DEPTH  = 1024,
    parameter int ADDR_W = 10,
    parameter int DATA_W = 8
) (
    // Clock
    input  wire logic              clk,
    // Access
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);

    if (DEPTH > (1 << ADDR_W)) begin : g_depth_chk
        $error("icva_cv_mem: DEPTH does not fit ADDR_W");
    end

    logic [DATA_W-1:0] store [DEPTH];

    // No reset on the array: contents are kept by software
    always_ff @(posedge clk) begin
        if (we) begin
            store[addr] <= wdata;
        end
        rdata <= store[addr];
    end

endmodule // icva_cv_mem
`default_nettype wire

// >>> testbench/icva_station.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Command station writing variables over the track
// ****************************************************************
module icva_station (
    // Clock
    input  wire logic                  clk,
    // Variable write
    output var  logic                  wr_valid,
    output var  icva_pkg::icva_cv_wr_s wr_req
);
    initial begin
        wr_valid = 1'b0;
        wr_req   = '0;
    end

    // One write, held from a falling edge to the taking rising edge
    task automatic put(input icva_pkg::icva_cv_num_t num, input icva_pkg::icva_byte_t data);
        @(negedge clk);
        wr_valid    = 1'b1;
        wr_req.num  = num;
        wr_req.data = data;
        @(posedge clk);
    endtask

    // Released lines show the inverse so no stale value looks valid
    task automatic idle();
        @(negedge clk);
        wr_valid = 1'b0;
        wr_req   = ~wr_req;
    endtask

    // Staged write: target helpers first, value trigger last
    task automatic indirect(input int target, input int value, input bit four);
        put(icva_pkg::CV_TGT_HUNDREDS, 8'(target / 100));
        put(icva_pkg::CV_TGT_TENS_UNITS, 8'(target % 100));
        if (four) begin
            put(icva_pkg::CV_VAL_HUNDREDS, 8'(value / 100));
            put(icva_pkg::CV_VAL_TRIGGER, 8'(value % 100));
        end else begin
            put(icva_pkg::CV_VAL_TRIGGER, 8'(value));
        end
        idle();
    endtask
endmodule // icva_station
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end
// ****************************************************************
// Self-checking bench of the indirect variable writer
// ****************************************************************
module tb;
    logic                      clk = 1'b0;
    logic                      rstn = 1'b0;
    logic                      wr_valid;
    icva_pkg::icva_cv_wr_s     wr_req;
    logic                      wr_ready;
    logic                      rd_valid = 1'b0;
    icva_pkg::icva_cv_num_t    rd_num = '0;
    logic                      rd_ready;
    logic                      rd_data_valid;
    icva_pkg::icva_byte_t      rd_data;
    icva_pkg::icva_byte_t      got;
    icva_pkg::icva_addr_sel_s  addr_sel;
    logic                      xfer_done;
    logic                      xfer_discard;
    int                        n_errors = 0;
    int                        total_checks = 0;
    int                        n_done = 0;
    int                        n_disc = 0;
    int                        cycles = 0;

    icva_core icva_core_inst (.clk(clk), .rstn(rstn), .wr_valid(wr_valid), .wr_req(wr_req),
        .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_num(rd_num), .rd_ready(rd_ready),
        .rd_data_valid(rd_data_valid), .rd_data(rd_data), .addr_sel(addr_sel),
        .xfer_done(xfer_done), .xfer_discard(xfer_discard));
    icva_station icva_station_inst (.clk(clk), .wr_valid(wr_valid), .wr_req(wr_req));

    always #20 clk = ~clk;

    // Pulse counters and hang guard
    always @(posedge clk) begin
        cycles++;
        if (xfer_done === 1'b1) n_done++;
        if (xfer_discard === 1'b1) n_disc++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Let pulses and the registered address land
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Read; the one-cycle answer pulse is looked at just after the edge that raises it
    task automatic rd(input icva_pkg::icva_cv_num_t n);
        @(negedge clk);
        rd_valid = 1'b1;
        rd_num   = n;
        @(posedge clk);
        @(negedge clk);
        rd_valid = 1'b0;
        rd_num   = ~n;
        @(posedge clk);
        #1;
        `CHK(rd_data_valid, 1'b1)
        got = rd_data;
    endtask

    task automatic t_reset();
        `CHK(addr_sel, {14'h0003, 1'b0, 1'b1})
        `CHK(wr_ready, 1'b1)
        `CHK(rd_ready, 1'b1)
    endtask

    task automatic t_three();
        icva_station_inst.indirect(317, 120, 1'b0);
        settle();
        `CHK(n_done, 1)
        rd(10'h13d); `CHK(got, 8'h78)
        rd(10'h060); `CHK(got, 8'h00)
        rd(10'h061); `CHK(got, 8'h00)
        rd(10'h063); `CHK(got, 8'h00)
        icva_station_inst.indirect(999, 255, 1'b0);
        settle();
        rd(10'h3e7); `CHK(got, 8'hff)
    endtask

    task automatic t_four();
        icva_station_inst.indirect(412, 255, 1'b1);
        settle();
        `CHK(n_done, 3)
        rd(10'h19c); `CHK(got, 8'hff)
        rd(10'h062); `CHK(got, 8'h00)
        rd(10'h061); `CHK(got, 8'h00)
        icva_station_inst.indirect(412, 7, 1'b0);
        settle();
        rd(10'h19c); `CHK(got, 8'h07)
    endtask

    task automatic t_discard();
        icva_station_inst.indirect(412, 256, 1'b1);
        settle();
        `CHK(n_disc, 1)
        `CHK(n_done, 4)
        rd(10'h19c); `CHK(got, 8'h07)
        rd(10'h062); `CHK(got, 8'h00)
        icva_station_inst.indirect(98, 5, 1'b0);
        settle();
        `CHK(n_disc, 2)
        rd(10'h060); `CHK(got, 8'h00)
        icva_station_inst.put(icva_pkg::CV_TGT_HUNDREDS, 8'h0a);
        icva_station_inst.put(icva_pkg::CV_TGT_TENS_UNITS, 8'h00);
        icva_station_inst.put(icva_pkg::CV_VAL_TRIGGER, 8'h01);
        icva_station_inst.idle();
        settle();
        `CHK(n_disc, 3)
        `CHK(n_done, 4)
    endtask

    task automatic t_addr();
        icva_station_inst.put(icva_pkg::CV_SHORT_ADDRESS, 8'h7f);
        icva_station_inst.put(icva_pkg::CV_LONG_ADDR_HIGH, 8'he7);
        icva_station_inst.put(icva_pkg::CV_LONG_ADDR_LOW, 8'hff);
        `CHK(rd_ready, 1'b0)
        icva_station_inst.idle();
        settle();
        `CHK(addr_sel, {14'h007f, 1'b0, 1'b1})
        icva_station_inst.put(icva_pkg::CV_BASIC_CONFIG, 8'h10);
        icva_station_inst.idle();
        settle();
        `CHK(addr_sel, {14'h007f, 1'b0, 1'b1})
        icva_station_inst.put(icva_pkg::CV_BASIC_CONFIG, 8'h20);
        icva_station_inst.idle();
        settle();
        `CHK(addr_sel, {14'h27ff, 1'b1, 1'b1})
        icva_station_inst.put(icva_pkg::CV_BASIC_CONFIG, 8'h00);
        icva_station_inst.idle();
        settle();
        `CHK(addr_sel, {14'h007f, 1'b0, 1'b1})
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        settle();
        t_reset();
        t_three();
        t_four();
        t_discard();
        t_addr();
        conclude();
    end
endmodule // tb
`undef CHK
`default_nettype wire
